//--- core/tsfm_params.svh
// register map, field positions and timing figures of the fault monitor
`ifndef TSFM_PARAMS_SVH
`define TSFM_PARAMS_SVH
// clock rate
`define TSFM_CLK_MHZ 50
// over-temperature filter time in microseconds
`define TSFM_OT_FILTER_US 20
// 5 v overvoltage filter time in microseconds (plain default)
`define TSFM_OV_FILTER_US 20
// power-latch exit delay in milliseconds, nominal of the 1.4 to 2.6 window
`define TSFM_EXIT_DELAY_MS 2
// register byte offsets
`define TSFM_OFS_LIVE 8'h00
`define TSFM_OFS_FLAGS 8'h04
`define TSFM_OFS_CONTROL 8'h08
`define TSFM_OFS_OUT_CTRL 8'h0c
`define TSFM_OFS_IRQ_STATUS 8'h10
`define TSFM_OFS_IRQ_CLEAR 8'h14
`define TSFM_OFS_IRQ_ENABLE 8'h18
// live status fields
`define TSFM_LIVE_UV3V3 4
`define TSFM_LIVE_TRK1 5
`define TSFM_LIVE_TRK2 6
`define TSFM_LIVE_TRKOVL 7
`define TSFM_LIVE_OVSHUT 8
`define TSFM_LIVE_EXIT 9
`define TSFM_LIVE_OVNOW 10
// flag and event fields
`define TSFM_FLAG_OV 4
`define TSFM_EVT_EXIT 5
// control fields
`define TSFM_CTRL_MRD 8
`define TSFM_CTRL_START 16
// drivers that stay on through a 5 v overvoltage: outputs 13, 14, 21, 25
`define TSFM_OV_KEEP_MASK 32'h0110_3000
// bus responses
`define TSFM_RESP_OKAY 2'h0
`define TSFM_RESP_SLVERR 2'h2
`endif

//--- core/tsfm_pkg.sv
// shared types of the fault monitor
package tsfm_pkg;
  typedef logic [31:0] tsfm_word_t;
  // sensor order inside every four-bit vector
  typedef enum logic [1:0] {
    TSFM_SNS_TRACK,
    TSFM_SNS_POWER,
    TSFM_SNS_RELAY,
    TSFM_SNS_LOW
  } tsfm_sensor_e;
endpackage

//--- core/tsfm_monitor.sv
// thermal and supply fault monitor with an axi4-lite register slave
//
// Overview of operation
// - tracking overtemp plus current limit cuts tracking supplies
// - power-stage overtemp cuts all outputs and ignition
// - relay overtemp cuts main relay driver
// - low regulator overtemp plus limit cuts 3.3 v
// - cool below hysteresis for filter time restores
// - latch four thermal warning flags, readable
// - reading warning flags clears them
// - outputs follow filtered state, not latched flags
// - 5 v overvoltage cuts drivers except kept four
// - 5 v overvoltage flag latched, cleared on read
// - overvoltage flag alone never blocks driver switch-on
// - 3.3 v off only with warning and overcurrent
// - 3.3 v undervoltage bit is live, unlatched
// - per-channel tracking overvoltage bits are live
// - tracking off only with warning and overcurrent
// - combined tracking overload bit is live
// - power-latch exit delay counter, two milliseconds
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "tsfm_params.svh"
module tsfm_monitor
  import tsfm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int N_OUT = 32,
  parameter int N_IGN = 4,
  parameter int OT_FILT_CYC = `TSFM_OT_FILTER_US * `TSFM_CLK_MHZ,
  parameter int OV_FILT_CYC = `TSFM_OV_FILTER_US * `TSFM_CLK_MHZ,
  parameter int EXIT_CYC = `TSFM_EXIT_DELAY_MS * 1000 * `TSFM_CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analog comparator pins, asynchronous
  input wire logic [3:0] temp_above_thr,
  input wire logic [3:0] temp_below_hyst,
  input wire logic trk_current_limit,
  input wire logic reg3v3_current_limit,
  input wire logic supply5_ov_detect,
  input wire logic reg3v3_uv_detect,
  input wire logic trk1_ov_detect,
  input wire logic trk2_ov_detect,
  input wire logic latch_exit_req,
  // driver and supply enables
  output logic [N_OUT-1:0] output_drivers,
  output logic [N_IGN-1:0] ignition_predrivers,
  output logic main_relay_driver,
  output logic regulator_3v3_output,
  output logic sensor_tracking_supplies,
  output logic power_latch_exit_delay,
  // interrupt, level
  output logic irq
);
  localparam int OT_CW = $clog2(OT_FILT_CYC + 1);
  localparam int OV_CW = $clog2(OV_FILT_CYC + 1);
  localparam int EX_CW = $clog2(EXIT_CYC + 1);
  localparam int N_IN = 15;
  localparam int N_EVT = 6;
  localparam logic [N_OUT-1:0] OV_KEEP = N_OUT'(`TSFM_OV_KEEP_MASK);

  // byte-lane merge used by the control, output and interrupt-enable registers
  function automatic tsfm_word_t merge_strb(tsfm_word_t old, tsfm_word_t nw, logic [3:0] st);
    tsfm_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // address decode shared by the read and write paths
  function automatic logic is_mapped(logic [ADDR_W-1:0] a);
    return (a == ADDR_W'(`TSFM_OFS_LIVE)) || (a == ADDR_W'(`TSFM_OFS_FLAGS)) ||
           (a == ADDR_W'(`TSFM_OFS_CONTROL)) || (a == ADDR_W'(`TSFM_OFS_OUT_CTRL)) ||
           (a == ADDR_W'(`TSFM_OFS_IRQ_STATUS)) || (a == ADDR_W'(`TSFM_OFS_IRQ_CLEAR)) ||
           (a == ADDR_W'(`TSFM_OFS_IRQ_ENABLE));
  endfunction

  // two-stage synchroniser for every pin; only the second stage is read
  logic [N_IN-1:0] sync1_q;
  logic [N_IN-1:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {latch_exit_req, trk2_ov_detect, trk1_ov_detect, reg3v3_uv_detect,
                  supply5_ov_detect, reg3v3_current_limit, trk_current_limit,
                  temp_below_hyst, temp_above_thr};
      sync2_q <= sync1_q;
    end
  end
  wire logic [3:0] hot_s = sync2_q[3:0];
  wire logic [3:0] cool_s = sync2_q[7:4];
  wire logic trk_cl_s = sync2_q[8];
  wire logic reg_cl_s = sync2_q[9];
  wire logic ov_s = sync2_q[10];
  wire logic uv_s = sync2_q[11];
  wire logic trk1_ov_s = sync2_q[12];
  wire logic trk2_ov_s = sync2_q[13];
  wire logic exit_req_s = sync2_q[14];

  // filtered fault states and their persistence counters
  logic [3:0] ot_q, ot_d; // filtered over-temperature per sensor
  logic [OT_CW-1:0] ot_cnt_q [4];
  logic [OT_CW-1:0] ot_cnt_d [4];
  logic ov_q, ov_d; // filtered 5 v overvoltage
  logic [OV_CW-1:0] ov_cnt_q, ov_cnt_d;
  logic exit_q, exit_d; // exit delay elapsed
  logic [EX_CW-1:0] ex_cnt_q, ex_cnt_d;

  // filters: an over-temperature or overvoltage state flips only after its opposite comparison held the whole interval
  always_comb begin
    ot_d = ot_q;
    ov_d = ov_q;
    ov_cnt_d = ov_cnt_q;
    exit_d = exit_q;
    ex_cnt_d = ex_cnt_q;
    for (int k = 0; k < 4; k++) begin
      ot_cnt_d[k] = ot_cnt_q[k];
      // hot side counts toward shutdown, cool side toward recovery
      if (!(ot_q[k] ? cool_s[k] : hot_s[k])) begin
        ot_cnt_d[k] = '0;
      end else if (ot_cnt_q[k] == OT_CW'(OT_FILT_CYC - 1)) begin
        ot_d[k] = ~ot_q[k];
        ot_cnt_d[k] = '0;
      end else begin
        ot_cnt_d[k] = ot_cnt_q[k] + OT_CW'(1);
      end
    end
    // overvoltage filtered the same way in both directions
    if (ov_s == ov_q) begin
      ov_cnt_d = '0;
    end else if (ov_cnt_q == OV_CW'(OV_FILT_CYC - 1)) begin
      ov_d = ov_s;
      ov_cnt_d = '0;
    end else begin
      ov_cnt_d = ov_cnt_q + OV_CW'(1);
    end
    // exit delay runs while requested and restarts when the request drops
    if (!exit_req_s) begin
      exit_d = 1'b0;
      ex_cnt_d = '0;
    end else if (!exit_q) begin
      if (ex_cnt_q == EX_CW'(EXIT_CYC - 1)) begin
        exit_d = 1'b1;
      end else begin
        ex_cnt_d = ex_cnt_q + EX_CW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ot_q <= '0;
      ov_q <= 1'b0;
      ov_cnt_q <= '0;
      exit_q <= 1'b0;
      ex_cnt_q <= '0;
      for (int k = 0; k < 4; k++) begin
        ot_cnt_q[k] <= '0;
      end
    end else begin
      ot_q <= ot_d;
      ov_q <= ov_d;
      ov_cnt_q <= ov_cnt_d;
      exit_q <= exit_d;
      ex_cnt_q <= ex_cnt_d;
      for (int k = 0; k < 4; k++) begin
        ot_cnt_q[k] <= ot_cnt_d[k];
      end
    end
  end

  // bus handshake state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  tsfm_word_t wdat_q, wdat_d;
  logic [3:0] wst_q, wst_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  tsfm_word_t rdata_q, rdata_d;
  wire logic do_wr = aw_held_q && w_held_q && !bvalid_q; // both halves in, slot free
  wire logic ar_hs = arvalid && arready_q;

  // register contents
  logic [3:0] warn_q, warn_d; // latched thermal warnings
  logic ovflag_q, ovflag_d; // latched 5 v overvoltage
  logic [N_IGN-1:0] ign_req_q, ign_req_d;
  logic mrd_req_q, mrd_req_d;
  tsfm_word_t out_req_q, out_req_d;
  logic ov_shut_q, ov_shut_d; // drivers held off after overvoltage
  logic start_seen_q, start_seen_d; // restart command received
  logic [N_EVT-1:0] ist_q, ist_d, ien_q, ien_d;
  logic [3:0] ot_prev_q;
  logic ov_prev_q, exit_prev_q;
  tsfm_word_t live_w;
  logic [N_EVT-1:0] evt;
  // strobe-merged images of the narrow writable registers; a call result cannot be sliced
  tsfm_word_t ign_m, ien_m;
  assign ign_m = merge_strb(32'(ign_req_q), wdat_q, wst_q);
  assign ien_m = merge_strb(32'(ien_q), wdat_q, wst_q);

  // live, unlatched view of the block
  always_comb begin
    live_w = '0;
    live_w[3:0] = ot_q;
    live_w[`TSFM_LIVE_UV3V3] = uv_s;
    live_w[`TSFM_LIVE_TRK1] = trk1_ov_s;
    live_w[`TSFM_LIVE_TRK2] = trk2_ov_s;
    live_w[`TSFM_LIVE_TRKOVL] = trk_cl_s || ot_q[TSFM_SNS_TRACK];
    live_w[`TSFM_LIVE_OVSHUT] = ov_shut_q;
    live_w[`TSFM_LIVE_EXIT] = exit_q;
    live_w[`TSFM_LIVE_OVNOW] = ov_q;
    evt = {exit_q && !exit_prev_q, ov_q && !ov_prev_q, ot_q & ~ot_prev_q};
  end

  // bus channels and register updates; a hardware set always beats a clear
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    wst_d = wst_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    warn_d = warn_q;
    ovflag_d = ovflag_q;
    ign_req_d = ign_req_q;
    mrd_req_d = mrd_req_q;
    out_req_d = out_req_q;
    ov_shut_d = ov_shut_q;
    start_seen_d = start_seen_q;
    ist_d = ist_q;
    ien_d = ien_q;
    // capture address and data in either order
    if (awvalid && awready_q) begin
      aw_held_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdat_d = wdata;
      wst_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(waddr_q) ? `TSFM_RESP_OKAY : `TSFM_RESP_SLVERR;
      if (waddr_q == ADDR_W'(`TSFM_OFS_CONTROL)) begin
        ign_req_d = ign_m[N_IGN-1:0];
        mrd_req_d = wst_q[1] ? wdat_q[`TSFM_CTRL_MRD] : mrd_req_q;
        if (wst_q[2] && wdat_q[`TSFM_CTRL_START]) begin
          start_seen_d = 1'b1;
        end
        // control rewrite after the restart command lifts the hold
        if (start_seen_q) begin
          ov_shut_d = 1'b0;
        end
      end
      if (waddr_q == ADDR_W'(`TSFM_OFS_OUT_CTRL)) begin
        out_req_d = merge_strb(out_req_q, wdat_q, wst_q);
        if (start_seen_q) begin
          ov_shut_d = 1'b0;
        end
      end
      if (waddr_q == ADDR_W'(`TSFM_OFS_IRQ_CLEAR)) begin
        ist_d = ist_d & ~wdat_q[N_EVT-1:0];
      end
      if (waddr_q == ADDR_W'(`TSFM_OFS_IRQ_ENABLE)) begin
        ien_d = ien_m[N_EVT-1:0];
      end
    end
    // reads: one at a time, answered the cycle after the address is taken
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(araddr) ? `TSFM_RESP_OKAY : `TSFM_RESP_SLVERR;
      rdata_d = '0;
      unique case (araddr)
        ADDR_W'(`TSFM_OFS_LIVE): rdata_d = live_w;
        ADDR_W'(`TSFM_OFS_FLAGS): begin
          rdata_d[3:0] = warn_q;
          rdata_d[`TSFM_FLAG_OV] = ovflag_q;
          warn_d = '0;
          ovflag_d = 1'b0;
        end
        ADDR_W'(`TSFM_OFS_CONTROL): begin
          rdata_d[N_IGN-1:0] = ign_req_q;
          rdata_d[`TSFM_CTRL_MRD] = mrd_req_q;
        end
        ADDR_W'(`TSFM_OFS_OUT_CTRL): rdata_d = out_req_q;
        ADDR_W'(`TSFM_OFS_IRQ_STATUS): rdata_d[N_EVT-1:0] = ist_q;
        ADDR_W'(`TSFM_OFS_IRQ_ENABLE): rdata_d[N_EVT-1:0] = ien_q;
        default: rdata_d = '0; // clear register and unmapped read as zero
      endcase
    end
    // hardware sets applied last so they win over a same-cycle clear
    warn_d = warn_d | ot_q;
    ovflag_d = ovflag_d | ov_q;
    ist_d = ist_d | evt;
    if (ov_q) begin
      ov_shut_d = 1'b1;
      start_seen_d = 1'b0;
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdat_q <= '0;
      wst_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `TSFM_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `TSFM_RESP_OKAY;
      rdata_q <= '0;
      warn_q <= '0;
      ovflag_q <= 1'b0;
      ign_req_q <= '0;
      mrd_req_q <= 1'b0;
      out_req_q <= '0;
      ov_shut_q <= 1'b0;
      start_seen_q <= 1'b0;
      ist_q <= '0;
      ien_q <= '0;
      ot_prev_q <= '0;
      ov_prev_q <= 1'b0;
      exit_prev_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wst_q <= wst_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      warn_q <= warn_d;
      ovflag_q <= ovflag_d;
      ign_req_q <= ign_req_d;
      mrd_req_q <= mrd_req_d;
      out_req_q <= out_req_d;
      ov_shut_q <= ov_shut_d;
      start_seen_q <= start_seen_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      ot_prev_q <= ot_q;
      ov_prev_q <= ov_q;
      exit_prev_q <= exit_q;
    end
  end

  // output stage: gates use the filtered states, the synchronised current limits and the overvoltage hold, never the latched flags
  logic [N_OUT-1:0] drv_q, drv_d;
  logic [N_IGN-1:0] ign_q, ign_d;
  logic mrd_q, mrd_d, v33_q, v33_d, trk_q, trk_d, exd_q, irq_q, irq_d;
  always_comb begin
    drv_d = out_req_q[N_OUT-1:0];
    if (ov_shut_q) begin
      drv_d = drv_d & OV_KEEP;
    end
    if (ot_q[TSFM_SNS_POWER]) begin
      drv_d = '0;
    end
    ign_d = ot_q[TSFM_SNS_POWER] || ov_shut_q ? '0 : ign_req_q;
    mrd_d = mrd_req_q && !ot_q[TSFM_SNS_RELAY];
    v33_d = !(ot_q[TSFM_SNS_LOW] && reg_cl_s);
    trk_d = !(ot_q[TSFM_SNS_TRACK] && trk_cl_s);
    irq_d = |(ist_q & ien_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_q <= '0;
      ign_q <= '0;
      mrd_q <= 1'b0;
      v33_q <= 1'b1;
      trk_q <= 1'b1;
      exd_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      ign_q <= ign_d;
      mrd_q <= mrd_d;
      v33_q <= v33_d;
      trk_q <= trk_d;
      exd_q <= exit_q;
      irq_q <= irq_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign arready = arready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign output_drivers = drv_q;
  assign ignition_predrivers = ign_q;
  assign main_relay_driver = mrd_q;
  assign regulator_3v3_output = v33_q;
  assign sensor_tracking_supplies = trk_q;
  assign power_latch_exit_delay = exd_q;
  assign irq = irq_q;

  // checks on the protection behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_flag_read;
    ar_hs && (araddr == ADDR_W'(`TSFM_OFS_FLAGS));
  endsequence
  sequence s_power_release;
    ot_q[1] && cool_s[1] && (ot_cnt_q[1] == OT_CW'(OT_FILT_CYC - 1));
  endsequence
  property p_trk_off;
    ot_q[0] && trk_cl_s |=> !trk_q;
  endproperty
  a_trk_off: assert property (p_trk_off) else $error("tracking not cut");
  property p_power_off;
    ot_q[1] |=> (drv_q == '0) && (ign_q == '0);
  endproperty
  a_power_off: assert property (p_power_off) else $error("drivers not cut");
  property p_relay_off;
    ot_q[2] |=> !mrd_q;
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("relay not cut");
  property p_low_off;
    ot_q[3] && reg_cl_s |=> !v33_q;
  endproperty
  a_low_off: assert property (p_low_off) else $error("3v3 not cut");
  property p_restore;
    s_power_release |=> !ot_q[1];
  endproperty
  a_restore: assert property (p_restore) else $error("no recovery");
  property p_warn_latch;
    ot_q[2] |=> warn_q[2];
  endproperty
  a_warn_latch: assert property (p_warn_latch) else $error("warning not latched");
  property p_read_clear;
    s_flag_read ##0 !ot_q[0] |=> !warn_q[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared");
  property p_ov_cut;
    ov_shut_q && !ot_q[1] |=> ((drv_q & ~OV_KEEP) == '0) &&
      (drv_q == ($past(out_req_q) & OV_KEEP));
  endproperty
  a_ov_cut: assert property (p_ov_cut) else $error("overvoltage cut wrong");
  property p_ov_flag_free;
    ovflag_q && !ov_shut_q && !ot_q[1] |=> drv_q == $past(out_req_q);
  endproperty
  a_ov_flag_free: assert property (p_ov_flag_free) else $error("flag blocks");
  property p_low_need_both;
    !ot_q[3] || !reg_cl_s |=> v33_q;
  endproperty
  a_low_need_both: assert property (p_low_need_both) else $error("3v3 cut early");
  property p_trk_need_both;
    !(ot_q[0] && trk_cl_s) |=> trk_q;
  endproperty
  a_trk_need_both: assert property (p_trk_need_both) else $error("trk cut early");
  property p_restart;
    !ot_q[1] && !hot_s[1] |=> ot_cnt_q[1] == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("filter kept count");
  property p_exit;
    exit_req_s && !exit_q && (ex_cnt_q == EX_CW'(EXIT_CYC - 1)) |=> exit_q ##1 exd_q;
  endproperty
  a_exit: assert property (p_exit) else $error("exit delay wrong");
endmodule

//--- tb/tsfm_mcu.sv
// microcontroller model: axi4-lite master issuing single reads and writes
`timescale 1ns/10ps
module tsfm_mcu (
  // clock
  input wire logic aclk,
  // write address and data
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  // write response
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // idle bus at time zero, full words only
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
  end

  // one write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        a_ok = 1'b1;
      end
      if (wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end while (!(a_ok && w_ok));
    // the response only follows both halves; no cycle count assumed
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // one read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

//--- tb/tb_tsfm_monitor.sv
// self-checking bench of the thermal and supply fault monitor
`timescale 1ns/10ps
`include "tsfm_params.svh"
module tb_tsfm_monitor;
  import tsfm_pkg::*;
  // clock, reset and bus
  logic aclk, aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] awprot, arprot;
  // comparator pins
  logic [3:0] temp_above_thr, temp_below_hyst;
  logic trk_current_limit, reg3v3_current_limit, supply5_ov_detect, reg3v3_uv_detect;
  logic trk1_ov_detect, trk2_ov_detect, latch_exit_req;
  // watched enables
  logic [31:0] output_drivers, rd_data;
  logic [3:0] ignition_predrivers;
  logic main_relay_driver, regulator_3v3_output, sensor_tracking_supplies;
  logic power_latch_exit_delay, irq;
  // scoreboard
  int mismatches = 0;
  int cmp_count = 0;

  // short filters and exit count keep the run brief
  tsfm_monitor #(.OT_FILT_CYC(8), .OV_FILT_CYC(8), .EXIT_CYC(16)) dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .temp_above_thr, .temp_below_hyst, .trk_current_limit,
    .reg3v3_current_limit, .supply5_ov_detect, .reg3v3_uv_detect, .trk1_ov_detect,
    .trk2_ov_detect, .latch_exit_req, .output_drivers, .ignition_predrivers,
    .main_relay_driver, .regulator_3v3_output, .sensor_tracking_supplies,
    .power_latch_exit_delay, .irq);

  // bus master on the far side
  tsfm_mcu u_mcu (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp);

  // 50 mhz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // compare and count
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // mapped write, okay response expected
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_mcu.wr(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, `TSFM_RESP_OKAY});
  endtask

  // masked read compare
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    u_mcu.rd(a, d, r);
    check(n, d & m, e);
    check("rresp", {30'h0, r}, {30'h0, `TSFM_RESP_OKAY});
  endtask

  // all enables except the exit delay at once; s is {relay, 3v3, tracking}
  task automatic outs(input logic [31:0] o, input logic [3:0] g, input logic [2:0] s);
    check("drivers", output_drivers, o);
    check("ignition", {28'h0, ignition_predrivers}, {28'h0, g});
    check("mrd_3v3_trk", {29'h0, main_relay_driver, regulator_3v3_output,
      sensor_tracking_supplies}, {29'h0, s});
  endtask

  // heat one sensor, check shutdown, cool, check recovery and latched flag
  task automatic ot(input int s, input logic lim);
    trk_current_limit <= lim;
    reg3v3_current_limit <= lim;
    temp_above_thr[s] <= 1'b1;
    temp_below_hyst[s] <= 1'b0;
    wt(20);
    outs((s == 1) ? 32'h0 : '1, (s == 1) ? 4'h0 : 4'hf,
      {s != 2, !(s == 3 && lim), !(s == 0 && lim)});
    rchk("live_ot", `TSFM_OFS_LIVE, 32'hf, 32'h1 << s);
    temp_above_thr[s] <= 1'b0;
    temp_below_hyst[s] <= 1'b1;
    trk_current_limit <= 1'b0;
    reg3v3_current_limit <= 1'b0;
    wt(20);
    outs('1, 4'hf, 3'h7);
    rchk("flag_set", `TSFM_OFS_FLAGS, 32'hf, 32'h1 << s);
    rchk("flag_clr", `TSFM_OFS_FLAGS, 32'hf, 32'h0);
  endtask

  // verdict and end of run
  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    wt(20000);
    mismatches++;
    finish_test;
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    {awprot, arprot} = 6'h0;
    temp_above_thr = 4'h0;
    temp_below_hyst = 4'hf;
    {trk_current_limit, reg3v3_current_limit, supply5_ov_detect} = 3'h0;
    {reg3v3_uv_detect, trk1_ov_detect, trk2_ov_detect, latch_exit_req} = 4'h0;
    wt(20);
    aresetn <= 1'b1;
    wt(3);
    outs(32'h0, 4'h0, 3'b011);
    check("exit_irq", {30'h0, power_latch_exit_delay, irq}, 32'h0);
    wr(`TSFM_OFS_OUT_CTRL, '1);
    wr(`TSFM_OFS_CONTROL, 32'h10f);
    wt(3);
    outs('1, 4'hf, 3'h7);
    // two hot spells, each shorter than the filter, split by one cycle neither hot nor cool
    temp_below_hyst[2] <= 1'b0;
    repeat (2) begin
      temp_above_thr[2] <= 1'b1;
      wt(5);
      temp_above_thr[2] <= 1'b0;
      wt(1);
    end
    wt(20);
    check("glitch_mrd", {31'h0, main_relay_driver}, 32'h1);
    ot(0, 1'b0);
    ot(0, 1'b1);
    ot(1, 1'b1);
    ot(2, 1'b1);
    ot(3, 1'b0);
    ot(3, 1'b1);
    // 5 v overvoltage holds drivers until restart and rewrite
    supply5_ov_detect <= 1'b1;
    wt(20);
    outs(`TSFM_OV_KEEP_MASK, 4'h0, 3'h7);
    supply5_ov_detect <= 1'b0;
    wt(20);
    check("ov_hold", output_drivers, `TSFM_OV_KEEP_MASK);
    wr(`TSFM_OFS_CONTROL, 32'h1010f);
    wr(`TSFM_OFS_OUT_CTRL, '1);
    wt(3);
    outs('1, 4'hf, 3'h7);
    rchk("ov_flag", `TSFM_OFS_FLAGS, 32'h10, 32'h10);
    rchk("ov_flag_clr", `TSFM_OFS_FLAGS, 32'h10, 32'h0);
    // live diagnostic bits follow their pins
    reg3v3_uv_detect <= 1'b1;
    trk1_ov_detect <= 1'b1;
    wt(5);
    rchk("live_diag", `TSFM_OFS_LIVE, 32'hf0, 32'h30);
    reg3v3_uv_detect <= 1'b0;
    trk1_ov_detect <= 1'b0;
    trk2_ov_detect <= 1'b1;
    trk_current_limit <= 1'b1;
    wt(5);
    rchk("live_diag", `TSFM_OFS_LIVE, 32'hf0, 32'hc0);
    trk2_ov_detect <= 1'b0;
    trk_current_limit <= 1'b0;
    wt(5);
    rchk("live_diag", `TSFM_OFS_LIVE, 32'hf0, 32'h0);
    // exit delay raises its event; mask, unmask and clear it
    wr(`TSFM_OFS_IRQ_ENABLE, 32'h20);
    latch_exit_req <= 1'b1;
    wt(12);
    check("exit_early", {31'h0, power_latch_exit_delay}, 32'h0);
    wt(20);
    check("exit_done", {30'h0, power_latch_exit_delay, irq}, 32'h3);
    rchk("irq_status", `TSFM_OFS_IRQ_STATUS, 32'h20, 32'h20);
    wr(`TSFM_OFS_IRQ_ENABLE, 32'h0);
    wt(2);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(`TSFM_OFS_IRQ_ENABLE, 32'h20);
    wt(2);
    check("irq_unmasked", {31'h0, irq}, 32'h1);
    wr(`TSFM_OFS_IRQ_CLEAR, 32'h3f);
    wt(2);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    rchk("irq_status", `TSFM_OFS_IRQ_STATUS, 32'h3f, 32'h0);
    latch_exit_req <= 1'b0;
    wt(6);
    check("exit_drop", {31'h0, power_latch_exit_delay}, 32'h0);
    // unmapped place answers with an error and no data
    u_mcu.rd(8'h1c, rd_data, rs);
    check("unmapped_rd", {rs, rd_data[29:0]}, {`TSFM_RESP_SLVERR, 30'h0});
    u_mcu.wr(8'h1c, 32'h1, rs);
    check("unmapped_wr", {30'h0, rs}, {30'h0, `TSFM_RESP_SLVERR});
    finish_test;
  end
endmodule
